// ===== core/rsm_pkg.sv
// package: sizes, types and pin-side constants of the register stack memory
// Behaviour
// - sixteen words of four bits, four-bit word select, write data and read data
// - word is written while write strobe, chip select and load clock are all low
// - while all three stay low the word follows every change of write data
// - load clock rising with chip select low loads addressed word into output register
// - output register holds its word during writes, changes only on qualifying rise
// - output enable high floats all four read data outputs
// - output enable low drives read data outputs from the output register
package rsm_pkg;
  localparam int RSM_WORDS = 16;
  localparam int RSM_WIDTH = 4;
  localparam int RSM_AW = 4;
  localparam logic RSM_LOW = 1'h0;
  localparam logic RSM_HIGH = 1'h1;

  typedef logic [RSM_AW-1:0] rsm_addr_t;
  typedef logic [RSM_WIDTH-1:0] rsm_word_t;
  typedef rsm_word_t [RSM_WORDS-1:0] rsm_array_t;

  // synchronised pin sample
  typedef struct packed {
    rsm_addr_t word_select;
    rsm_word_t write_data_in;
    logic chip_select_n;
    logic write_strobe_n;
    logic register_load_clock;
    logic output_drive_enable_n;
  } rsm_pins_t;

  // state of the top module
  typedef struct packed {
    rsm_pins_t sync1;
    rsm_pins_t sync2;
    logic load_clock_prev;
    rsm_word_t out_reg;
    logic oe;
  } rsm_top_state_t;
endpackage

// ===== core/rsm_mem_if.sv
// interface: write and read port between control and the storage array
interface rsm_mem_if;
  import rsm_pkg::*;
  logic wr_en;
  rsm_addr_t wr_addr;
  rsm_word_t wr_data;
  rsm_addr_t rd_addr;
  rsm_word_t rd_data;

  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ===== core/rsm_array.sv
// storage array of sixteen four-bit words
module rsm_array
  import rsm_pkg::*;
(
  // clock
  input wire logic clk,
  // port to control
  rsm_mem_if.mem port
);
  typedef struct packed {
    rsm_array_t words;
  } rsm_array_state_t;

  rsm_array_state_t s_q;
  rsm_array_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (port.wr_en) begin
      s_d.words[port.wr_addr] = port.wr_data;
    end
  end

  // no reset on the array
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign port.rd_data = s_q.words[port.rd_addr];
endmodule

// ===== core/rsm_top.sv
// top: pin synchronisers, write control, output register and output drive
module rsm_top
  import rsm_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // controller side pins
  input wire logic [RSM_AW-1:0] WORD_SELECT,
  input wire logic [RSM_WIDTH-1:0] WRITE_DATA_IN,
  input wire logic CHIP_SELECT_N,
  input wire logic WRITE_STROBE_N,
  input wire logic REGISTER_LOAD_CLOCK,
  input wire logic OUTPUT_DRIVE_ENABLE_N,
  // read data pins
  output logic [RSM_WIDTH-1:0] READ_DATA_OUT,
  output logic READ_DATA_OE
);
  // state and its next value
  rsm_top_state_t s_q;
  rsm_top_state_t s_d;

  // raw pins and their synchronised view
  rsm_pins_t pins_in;
  rsm_pins_t pins_seen;

  // named parts of the synchronised view
  rsm_addr_t seen_addr;
  rsm_word_t seen_data;
  logic seen_load;

  // decoded controls
  logic write_now;
  logic load_rise;
  logic drive_now;

  // word at the synchronised address
  rsm_word_t word_read;

  // port between control and the storage array
  rsm_mem_if mem_bus ();

  // true when a synchronised pin is low
  function automatic logic level_low(input logic level);
    logic is_low;
    is_low = (level == RSM_LOW);
    return is_low;
  endfunction

  // write strobe, chip select and load clock all low
  function automatic logic write_condition(input rsm_pins_t pins);
    logic hit;
    case ({pins.write_strobe_n, pins.chip_select_n, pins.register_load_clock})
      3'h0: begin
        hit = RSM_HIGH;
      end
      default: begin
        hit = RSM_LOW;
      end
    endcase
    return hit;
  endfunction

  // load clock low one sample back and high now, with chip select low
  function automatic logic load_condition(input rsm_pins_t pins, input logic prev_level);
    logic hit;
    case ({prev_level, pins.register_load_clock, pins.chip_select_n})
      3'h2: begin
        hit = RSM_HIGH;
      end
      default: begin
        hit = RSM_LOW;
      end
    endcase
    return hit;
  endfunction

  // pins drive while the active-low enable is low
  function automatic logic drive_condition(input rsm_pins_t pins);
    logic enable_on;
    enable_on = level_low(pins.output_drive_enable_n);
    return enable_on;
  endfunction

  // a new word on a load, otherwise the held one
  function automatic rsm_word_t pick_word(input logic take, input rsm_word_t fresh,
      input rsm_word_t held);
    rsm_word_t result;
    if (take) begin
      result = fresh;
    end else begin
      result = held;
    end
    return result;
  endfunction

  // pin sample with all strobes inactive and the load clock high
  function automatic rsm_pins_t idle_pins();
    rsm_pins_t idle;
    idle.word_select = '0;
    idle.write_data_in = '0;
    idle.chip_select_n = RSM_HIGH;
    idle.write_strobe_n = RSM_HIGH;
    idle.register_load_clock = RSM_HIGH;
    idle.output_drive_enable_n = RSM_HIGH;
    return idle;
  endfunction

  // storage array
  rsm_array u_array (
    .clk(MCLK),
    .port(mem_bus.mem)
  );

  // raw pins gathered into one sample
  always_comb begin
    pins_in.word_select = WORD_SELECT;
    pins_in.write_data_in = WRITE_DATA_IN;
    pins_in.chip_select_n = CHIP_SELECT_N;
    pins_in.write_strobe_n = WRITE_STROBE_N;
    pins_in.register_load_clock = REGISTER_LOAD_CLOCK;
    pins_in.output_drive_enable_n = OUTPUT_DRIVE_ENABLE_N;
  end

  // decode from the second sync stage only; the first may be unsettled
  assign pins_seen = s_q.sync2;
  assign seen_addr = pins_seen.word_select;
  assign seen_data = pins_seen.write_data_in;
  assign seen_load = pins_seen.register_load_clock;
  assign write_now = write_condition(pins_seen);
  assign load_rise = load_condition(pins_seen, s_q.load_clock_prev);
  assign drive_now = drive_condition(pins_seen);

  // write and read port of the array
  assign mem_bus.wr_en = write_now;
  assign mem_bus.wr_addr = seen_addr;
  assign mem_bus.wr_data = seen_data;
  assign mem_bus.rd_addr = seen_addr;
  assign word_read = mem_bus.rd_data;

  always_comb begin
    s_d = s_q;

    // first stage takes the raw pins
    s_d.sync1.word_select = pins_in.word_select;
    s_d.sync1.write_data_in = pins_in.write_data_in;
    s_d.sync1.chip_select_n = pins_in.chip_select_n;
    s_d.sync1.write_strobe_n = pins_in.write_strobe_n;
    s_d.sync1.register_load_clock = pins_in.register_load_clock;
    s_d.sync1.output_drive_enable_n = pins_in.output_drive_enable_n;

    // second stage takes the first and nothing else
    s_d.sync2.word_select = s_q.sync1.word_select;
    s_d.sync2.write_data_in = s_q.sync1.write_data_in;
    s_d.sync2.chip_select_n = s_q.sync1.chip_select_n;
    s_d.sync2.write_strobe_n = s_q.sync1.write_strobe_n;
    s_d.sync2.register_load_clock = s_q.sync1.register_load_clock;
    s_d.sync2.output_drive_enable_n = s_q.sync1.output_drive_enable_n;

    // load clock level one sample back, for the edge detector
    s_d.load_clock_prev = seen_load;

    // output register moves only on a qualifying rise
    s_d.out_reg = pick_word(load_rise, word_read, s_q.out_reg);

    // output drive
    if (drive_now) begin
      s_d.oe = RSM_HIGH;
    end else begin
      s_d.oe = RSM_LOW;
    end

    // stages preset inactive so no write or load fires at release
    if (SYS_RST) begin
      s_d.sync1 = idle_pins();
      s_d.sync2 = idle_pins();
      s_d.load_clock_prev = RSM_HIGH;
      s_d.oe = RSM_LOW;
      s_d.out_reg = s_q.out_reg;
    end
  end

  // one register for the whole state
  always_ff @(posedge MCLK) begin
    s_q <= s_d;
  end

  // pins straight from the state flops
  assign READ_DATA_OUT = s_q.out_reg;
  assign READ_DATA_OE = s_q.oe;
endmodule

// ===== tb/rsm_host_model.sv
// controller side view of the read data wires
module rsm_host_model import rsm_pkg::*; (
  // read data pins and the wire seen
  input wire logic [3:0] p,
  input wire logic e,
  output wire logic [3:0] q
);
  timeunit 1ns;
  timeprecision 1ns;
  assign q = e ? p : 4'hZ;
endmodule

// ===== tb/rsm_checker.sv
// assertions on the pins of the register stack memory
module rsm_checker import rsm_pkg::*; (
  // watched pins
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic CHIP_SELECT_N,
  input wire logic REGISTER_LOAD_CLOCK,
  input wire logic OUTPUT_DRIVE_ENABLE_N,
  input wire logic [3:0] READ_DATA_OUT,
  input wire logic READ_DATA_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);
  a_oe_on: assert property ($fell(OUTPUT_DRIVE_ENABLE_N) |-> ##3 READ_DATA_OE)
    else $error("oe on");
  a_oe_off: assert property ($rose(OUTPUT_DRIVE_ENABLE_N) |-> ##3 !READ_DATA_OE)
    else $error("oe off");
  a_out_cause: assert property ($changed(READ_DATA_OUT) |->
    !$past(CHIP_SELECT_N, 3) && $past(REGISTER_LOAD_CLOCK, 3) && !$past(REGISTER_LOAD_CLOCK, 4))
    else $error("out");
  a_lc_low: assert property (!REGISTER_LOAD_CLOCK [*4] |-> $stable(READ_DATA_OUT))
    else $error("hold");
  a_oe_rst: assert property (disable iff (1'h0) SYS_RST |=> !READ_DATA_OE)
    else $error("rst");
  // four samples clear of reset, so both sync stages hold real pin levels
  sequence s_run;
    !SYS_RST [*4];
  endsequence
  a_oe_follow: assert property (s_run |->
    READ_DATA_OE == !$past(OUTPUT_DRIVE_ENABLE_N, 3))
    else $error("oe follow");
endmodule
bind rsm_top rsm_checker chk (.*);

// ===== tb/rsm_top_bench.sv
// bench for the register stack memory
module rsm_top_bench import rsm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic c = 0, r = 1, e = 0, o;
  logic [2:0] k = 3'h6;
  rsm_word_t a = 4'h0, d = 4'h0, y, q;
  int bad_count = 0, total_checks = 0;
  always #25 c = ~c;
  rsm_top dut (.MCLK(c), .SYS_RST(r), .WORD_SELECT(a), .WRITE_DATA_IN(d), .CHIP_SELECT_N(k[2]),
    .WRITE_STROBE_N(k[1]), .REGISTER_LOAD_CLOCK(k[0]), .OUTPUT_DRIVE_ENABLE_N(e),
    .READ_DATA_OUT(y), .READ_DATA_OE(o));
  rsm_host_model host (.p(y), .e(o), .q(q));
  // drive address, data and {cs_n, we_n, load}, then compare the wire
  task automatic p(rsm_word_t x, rsm_word_t v, logic [2:0] m, rsm_word_t w);
    {a, d, k} = {x, v, m};
    repeat (4) @(negedge c);
    total_checks++;
    if (q !== w) begin
      bad_count++;
      $display("MISMATCH read_data exp %h got %h", w, q);
    end
  endtask
  task automatic t_fill;
    for (int i = 0; i < 16; i++) begin
      p(4'(i), ~4'(i), 3'h0, 4'hX);
      p(4'(i), ~4'(i), 3'h2, 4'hX);
    end
    for (int i = 0; i < 16; i++) begin
      p(4'(i), 4'h0, 3'h3, ~4'(i));
      p(4'(i), 4'h0, 3'h2, ~4'(i));
    end
  endtask
  task automatic t_write;
    p(4'h5, 4'h3, 3'h0, 4'h0);
    p(4'h5, 4'h9, 3'h0, 4'h0);
    p(4'h5, 4'h6, 3'h7, 4'h0);
    p(4'h5, 4'h6, 3'h2, 4'h0);
    p(4'h5, 4'h6, 3'h3, 4'h9);
  endtask
  task automatic t_oe;
    e = 1;
    p(4'h5, 4'h6, 3'h2, 4'hZ);
    e = 0;
    p(4'h5, 4'h6, 3'h2, 4'h9);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge c);
    r = 0;
    t_fill;
    t_write;
    t_oe;
    summarize;
  end
endmodule
